/* icpb_top.sv */
// Purpose: Core interrupt control with port B change and external pin sources
// Assumes: AXI4-Lite slave, one clock, synchronous active-low reset
// Notes:   Port B pins pass a two-stage synchroniser before use
//
// Overview of operation
// [RULE1] Byte register of enables and flags
// [RULE2] Flags set regardless of any enable
// [RULE3] Global enable gates every request
// [RULE4] Peripheral enable gates peripheral requests
// [RULE5] External pin enable gates its request
// [RULE6] Port change enable gates its request
// [RULE7] Timer0 overflow flag set, software clears
// [RULE8] External pin flag set, software clears
// [RULE9] Upper pin change sets sticky flag
// [RULE10] Upper pins detect change, offer pull-up
// [RULE11] Low-voltage programming masks pin four
// [RULE12] All pins bidirectional with pull-up
// [RULE13] Direction and option reset to ones
// [RULE14] Control register mirrored in four banks
// [RULE15] Request is gated OR of sources
// [RULE16] Bits seven to one clear on reset
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module icpb_top
    import icpb_pkg::*;
(
    input  wire logic              CORE_CLK_I,
    input  wire logic              RESETN_I,
    input  wire logic [ADDR_W-1:0] AXI_AWADDR_I,
    input  wire logic              AXI_AWVALID_I,
    output var  logic              AXI_AWREADY_O,
    input  wire logic [31:0]       AXI_WDATA_I,
    input  wire logic [3:0]        AXI_WSTRB_I,
    input  wire logic              AXI_WVALID_I,
    output var  logic              AXI_WREADY_O,
    output var  logic [1:0]        AXI_BRESP_O,
    output var  logic              AXI_BVALID_O,
    input  wire logic              AXI_BREADY_I,
    input  wire logic [ADDR_W-1:0] AXI_ARADDR_I,
    input  wire logic              AXI_ARVALID_I,
    output var  logic              AXI_ARREADY_O,
    output var  logic [31:0]       AXI_RDATA_O,
    output var  logic [1:0]        AXI_RRESP_O,
    output var  logic              AXI_RVALID_O,
    input  wire logic              AXI_RREADY_I,
    input  wire logic [7:0]        PORT_B_PIN_DATA_PIN_I,
    output var  logic [7:0]        PORT_B_PIN_DATA_OUT_O,
    output var  logic [7:0]        PORT_B_PIN_DATA_OE_O,
    output var  logic [7:0]        PORT_B_PIN_DATA_PULLUP_O,
    input  wire logic              TIMER0_COUNT_OVF_I,
    input  wire logic              PERIPH_REQ_I,
    input  wire logic              LVP_EN_I,
    output var  logic [7:0]        OPTION_O,
    output var  logic              IRQ_O
);

    // Decode of a register index, used by both paths
    // [RULE14] Bank mirror decode
    function automatic icpb_sel_type reg_sel(input logic [IDX_W-1:0] idx);
        icpb_sel_type s;
        s = SEL_NONE;
        if (idx == IDX_PORT_B0 || idx == IDX_PORT_B2) begin
            s = SEL_PORT;
        end
        if (idx == IDX_INTCTL_B0 || idx == IDX_INTCTL_B1 || idx == IDX_INTCTL_B2 || idx == IDX_INTCTL_B3) begin
            s = SEL_INTCTL;
        end
        if (idx == IDX_OPTION_B1 || idx == IDX_OPTION_B3) begin
            s = SEL_OPTION;
        end
        if (idx == IDX_DIR_B1 || idx == IDX_DIR_B3) begin
            s = SEL_DIR;
        end
        return s;
    endfunction

    logic              aw_got;
    logic              w_got;
    logic [IDX_W-1:0]  w_idx;
    logic [7:0]        w_byte;
    logic              w_lane0;
    logic [7:0]        sync1;
    logic [7:0]        sync2;
    logic [7:0]        prev;
    logic [1:0]        arm;
    logic [7:0]        port_latch;
    logic [7:0]        dir;
    logic [7:0]        option;
    icpb_intctl_type   ctl;

    // Write channel
    wire               aw_hs       = AXI_AWVALID_I & AXI_AWREADY_O;
    wire               w_hs        = AXI_WVALID_I & AXI_WREADY_O;
    wire               do_write    = aw_got & w_got & ~AXI_BVALID_O;
    wire               next_aw_got = (aw_got | aw_hs) & ~do_write;
    wire               next_w_got  = (w_got | w_hs) & ~do_write;
    wire               next_bvalid = do_write | (AXI_BVALID_O & ~AXI_BREADY_I);
    wire icpb_sel_type wr_sel      = reg_sel(w_idx);
    wire               wr_en       = do_write & w_lane0;
    wire               port_wr     = wr_en & (wr_sel == SEL_PORT);
    wire               ctl_wr      = wr_en & (wr_sel == SEL_INTCTL);
    wire               opt_wr      = wr_en & (wr_sel == SEL_OPTION);
    wire               dir_wr      = wr_en & (wr_sel == SEL_DIR);

    // Read channel
    wire               ar_hs       = AXI_ARVALID_I & AXI_ARREADY_O;
    wire               next_rvalid = ar_hs | (AXI_RVALID_O & ~AXI_RREADY_I);
    wire icpb_sel_type rd_sel      = reg_sel(AXI_ARADDR_I[ADDR_W-1:2]);
    wire [7:0]         rd_byte     = (rd_sel == SEL_PORT)   ? sync2 :
                                     (rd_sel == SEL_INTCTL) ? ctl :
                                     (rd_sel == SEL_OPTION) ? option :
                                     (rd_sel == SEL_DIR)    ? dir : 8'h00;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            AXI_AWREADY_O <= 1'b0;
            AXI_WREADY_O  <= 1'b0;
            AXI_BVALID_O  <= 1'b0;
            AXI_BRESP_O   <= RESP_OKAY;
        end else begin
            aw_got        <= next_aw_got;
            w_got         <= next_w_got;
            AXI_AWREADY_O <= ~next_aw_got & ~next_bvalid;
            AXI_WREADY_O  <= ~next_w_got & ~next_bvalid;
            AXI_BVALID_O  <= next_bvalid;
            if (do_write) begin
                AXI_BRESP_O <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (aw_hs) begin
            w_idx <= AXI_AWADDR_I[ADDR_W-1:2];
        end
        if (w_hs) begin
            w_byte  <= AXI_WDATA_I[7:0];
            w_lane0 <= AXI_WSTRB_I[0];
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            AXI_ARREADY_O <= 1'b0;
            AXI_RVALID_O  <= 1'b0;
            AXI_RDATA_O   <= 32'h0000_0000;
            AXI_RRESP_O   <= RESP_OKAY;
        end else begin
            AXI_ARREADY_O <= ~next_rvalid;
            AXI_RVALID_O  <= next_rvalid;
            if (ar_hs) begin
                AXI_RDATA_O <= {24'h00_0000, rd_byte};
                AXI_RRESP_O <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
        end
    end

    // Pin synchroniser and edge history
    always_ff @(posedge CORE_CLK_I) begin
        sync1 <= PORT_B_PIN_DATA_PIN_I;
        sync2 <= sync1;
        prev  <= sync2;
    end

    // Hold off edge detection until history is valid
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            arm <= 2'h0;
        end else if (arm != ARM_DONE) begin
            arm <= arm + 2'h1;
        end
    end

    wire       armed     = (arm == ARM_DONE);
    wire       edge_rise = option[OPT_EDGE_BIT];
    wire       ext_event = armed & (edge_rise ? (sync2[EXT_PIN] & ~prev[EXT_PIN])
                                              : (~sync2[EXT_PIN] & prev[EXT_PIN]));
    wire [7:0] next_dir  = dir_wr ? w_byte : dir;
    wire [7:0] next_opt  = opt_wr ? w_byte : option;
    wire [7:0] chg;
    wire [7:0] next_pull;
    wire       rb_change = armed & (|chg);

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            localparam logic IS_LVP = (gi == LVP_PIN);
            localparam logic IS_UP  = (gi >= UPPER_LO);
            // [RULE10] [RULE11] [RULE12] Pull-up per input pin
            assign next_pull[gi] = ~next_opt[OPT_PULL_DIS_BIT] & next_dir[gi] & ~(IS_LVP & LVP_EN_I);
            // [RULE10] [RULE11] Change detect on upper pins
            assign chg[gi] = IS_UP & dir[gi] & (sync2[gi] ^ prev[gi]) & ~(IS_LVP & LVP_EN_I);
        end
    endgenerate

    // Data latch keeps its value over resets
    always_ff @(posedge CORE_CLK_I) begin
        if (port_wr) begin
            port_latch <= w_byte;
        end
        PORT_B_PIN_DATA_OUT_O <= port_wr ? w_byte : port_latch;
    end

    // [RULE13] Direction and option reset
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            dir            <= DIR_RESET;
            option         <= OPTION_RESET;
            OPTION_O       <= OPTION_RESET;
            PORT_B_PIN_DATA_OE_O     <= ~DIR_RESET;
            PORT_B_PIN_DATA_PULLUP_O <= 8'h00;
        end else begin
            dir            <= next_dir;
            option         <= next_opt;
            OPTION_O       <= next_opt;
            // [RULE12] Drive pins set as outputs
            PORT_B_PIN_DATA_OE_O     <= ~next_dir;
            PORT_B_PIN_DATA_PULLUP_O <= next_pull;
        end
    end

    // [RULE1] [RULE16] Control register reset and write
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            {ctl.global_irq_enable, ctl.peripheral_irq_enable, ctl.t0ie, ctl.ext_pin_irq_enable, ctl.port_change_irq_enable, ctl.timer0_overflow_flag, ctl.ext_pin_irq_flag} <= INTCTL_RESET;
        end else begin
            if (ctl_wr) begin
                {ctl.global_irq_enable, ctl.peripheral_irq_enable, ctl.t0ie, ctl.ext_pin_irq_enable, ctl.port_change_irq_enable} <= w_byte[7:3];
            end
            // [RULE2] [RULE7] Overflow flag, set wins
            ctl.timer0_overflow_flag <= TIMER0_COUNT_OVF_I | (ctl_wr ? w_byte[2] : ctl.timer0_overflow_flag);
            // [RULE2] [RULE8] Pin flag, set wins
            ctl.ext_pin_irq_flag <= ext_event | (ctl_wr ? w_byte[1] : ctl.ext_pin_irq_flag);
            // [RULE9] [RULE16] Change flag, no reset value
            ctl.port_change_flag <= rb_change | (ctl_wr ? w_byte[0] : ctl.port_change_flag);
        end
    end

    // [RULE3] [RULE4] [RULE5] [RULE6] [RULE15] Gated request
    wire next_irq = ctl.global_irq_enable & ((ctl.t0ie & ctl.timer0_overflow_flag) | (ctl.ext_pin_irq_enable & ctl.ext_pin_irq_flag) |
                               (ctl.port_change_irq_enable & ctl.port_change_flag) | (ctl.peripheral_irq_enable & PERIPH_REQ_I));

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= next_irq;
        end
    end

    // Checks
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);

    sequence s_ctl_write;
        ctl_wr;
    endsequence

    sequence s_quiet_ctl;
        !ctl_wr [*2];
    endsequence

    a_ovf_flag_set: assert property (TIMER0_COUNT_OVF_I |=> ctl.timer0_overflow_flag) // [RULE7]
        else $error("overflow flag not set");
    a_ovf_flag_hold: assert property (ctl.timer0_overflow_flag ##0 s_quiet_ctl |-> ctl.timer0_overflow_flag) // [RULE7]
        else $error("overflow flag cleared by hardware");
    a_ext_flag_set: assert property (ext_event && !ctl.ext_pin_irq_enable |=> ctl.ext_pin_irq_flag) // [RULE2]
        else $error("pin flag needs enable");
    a_ext_flag_hold: assert property (ctl.ext_pin_irq_flag && !ctl_wr |=> ctl.ext_pin_irq_flag) // [RULE8]
        else $error("pin flag lost");
    a_chg_flag_set: assert property (rb_change |=> ctl.port_change_flag) // [RULE9]
        else $error("change flag not set");
    a_gie_blocks: assert property (!ctl.global_irq_enable ##1 !ctl.global_irq_enable |-> !IRQ_O) // [RULE3]
        else $error("request without global enable");
    a_periph_pass: assert property (ctl.global_irq_enable && ctl.peripheral_irq_enable && PERIPH_REQ_I |=> IRQ_O) // [RULE4]
        else $error("peripheral request lost");
    a_periph_block: assert property (ctl.global_irq_enable && !ctl.peripheral_irq_enable && !ctl.t0ie && !ctl.ext_pin_irq_enable && !ctl.port_change_irq_enable |=> !IRQ_O) // [RULE4]
        else $error("masked sources raised request");
    a_ext_pass: assert property (ctl.global_irq_enable && ctl.ext_pin_irq_enable && ctl.ext_pin_irq_flag |=> IRQ_O) // [RULE5]
        else $error("pin request lost");
    a_chg_pass: assert property (ctl.global_irq_enable && ctl.port_change_irq_enable && ctl.port_change_flag |=> IRQ_O) // [RULE6]
        else $error("change request lost");
    a_lvp_pullup: assert property (LVP_EN_I |=> !PORT_B_PIN_DATA_PULLUP_O[LVP_PIN]) // [RULE11]
        else $error("pin four pull-up on in programming mode");
    a_lvp_nochg: assert property (LVP_EN_I |-> !chg[LVP_PIN]) // [RULE11]
        else $error("pin four change seen in programming mode");
    a_mirror_write: assert property (s_ctl_write |=> ctl.global_irq_enable == $past(w_byte[7])) // [RULE14]
        else $error("control write not applied");
    a_dir_reset: assert property (disable iff (1'b0) !RESETN_I |=> dir == DIR_RESET && option == OPTION_RESET) // [RULE13]
        else $error("reset values wrong");
    a_read_answer: assert property (ar_hs |=> AXI_RVALID_O) // [RULE1]
        else $error("read not answered");
    a_write_answer: assert property (aw_got && w_got && !AXI_BVALID_O |=> AXI_BVALID_O) // [RULE1]
        else $error("write not answered");
    a_bvalid_hold: assert property (AXI_BVALID_O && !AXI_BREADY_I |=> AXI_BVALID_O) // [RULE1]
        else $error("write answer dropped");
    a_ar_block: assert property (AXI_RVALID_O |-> !AXI_ARREADY_O) // [RULE1]
        else $error("read taken while busy");
    a_write_slverr: assert property (do_write && wr_sel == SEL_NONE |=> AXI_BRESP_O == RESP_SLVERR) // [RULE14]
        else $error("unmapped write accepted");

    sequence s_timer_armed;
        ctl.global_irq_enable && ctl.t0ie && ctl.timer0_overflow_flag;
    endsequence

    sequence s_all_masked;
        !ctl.peripheral_irq_enable && !ctl.t0ie && !ctl.ext_pin_irq_enable && !ctl.port_change_irq_enable;
    endsequence

    sequence s_ext_seen;
        ext_event ##1 !ctl_wr;
    endsequence

    // Request paths
    a_timer_pass: assert property (s_timer_armed |=> IRQ_O) // [RULE15]
        else $error("timer request lost");
    a_masked_quiet: assert property (s_all_masked |=> !IRQ_O) // [RULE15]
        else $error("request with all sources masked");
    a_rst_irq_low: assert property (disable iff (1'b0) !RESETN_I |=> !IRQ_O) // [RULE3]
        else $error("request during reset");

    // Flag set wins over clear, no set without event, pin flag held
    a_ovf_set_wins: assert property (TIMER0_COUNT_OVF_I && ctl_wr |=> ctl.timer0_overflow_flag) // [RULE2]
        else $error("overflow flag lost to clear");
    a_ext_set_wins: assert property (ext_event && ctl_wr |=> ctl.ext_pin_irq_flag) // [RULE2]
        else $error("pin flag lost to clear");
    a_chg_set_wins: assert property (rb_change && ctl_wr |=> ctl.port_change_flag) // [RULE2]
        else $error("change flag lost to clear");
    a_ovf_no_self: assert property (!ctl.timer0_overflow_flag && !TIMER0_COUNT_OVF_I && !ctl_wr |=> !ctl.timer0_overflow_flag) // [RULE7]
        else $error("overflow flag set without event");
    a_ext_sticky: assert property (s_ext_seen |=> ctl.ext_pin_irq_flag) // [RULE8]
        else $error("pin flag not kept");

    // Change detect scope
    a_low_nochg: assert property (chg[3:0] == 4'h0) // [RULE9]
        else $error("change seen on lower pins");
    a_out_nochg: assert property ((chg[7:4] & ~dir[7:4]) == 4'h0) // [RULE10]
        else $error("change seen on output pin");

    // Pin, option and interrupt control registers
    a_oe_dir: assert property (PORT_B_PIN_DATA_OE_O == ~dir) // [RULE12]
        else $error("drive enable differs from direction");
    a_pull_off: assert property (option[OPT_PULL_DIS_BIT] |-> PORT_B_PIN_DATA_PULLUP_O == 8'h00) // [RULE12]
        else $error("pull-up on while disabled");
    a_opt_copy: assert property (OPTION_O == option) // [RULE13]
        else $error("option output differs");
    a_rst_ctl: assert property (disable iff (1'b0) !RESETN_I |=> !ctl.global_irq_enable && !ctl.ext_pin_irq_flag && !ctl.timer0_overflow_flag) // [RULE16]
        else $error("control bits not cleared");
    a_alias_read: assert property (ar_hs && rd_sel == SEL_INTCTL |=> AXI_RDATA_O[7:1] == $past(ctl[7:1])) // [RULE14]
        else $error("mirror read differs");

endmodule
`default_nettype wire

/* icpb_pkg.sv */
// Purpose: Shared constants and types of the core interrupt and port B block
// Assumes: Register indices times four give the AXI4-Lite byte address
// Notes:   One package for the single design file
package icpb_pkg;
    localparam int          ADDR_W         = 12;
    localparam int          IDX_W          = 10;
    // Register indices in each bank that maps them
    localparam logic [9:0]  IDX_PORT_B0    = 10'h006;
    localparam logic [9:0]  IDX_PORT_B2    = 10'h106;
    localparam logic [9:0]  IDX_INTCTL_B0  = 10'h00b;
    localparam logic [9:0]  IDX_INTCTL_B1  = 10'h08b;
    localparam logic [9:0]  IDX_INTCTL_B2  = 10'h10b;
    localparam logic [9:0]  IDX_INTCTL_B3  = 10'h18b;
    localparam logic [9:0]  IDX_OPTION_B1  = 10'h081;
    localparam logic [9:0]  IDX_OPTION_B3  = 10'h181;
    localparam logic [9:0]  IDX_DIR_B1     = 10'h086;
    localparam logic [9:0]  IDX_DIR_B3     = 10'h186;
    // Option field positions
    localparam int          OPT_PULL_DIS_BIT = 7;
    localparam int          OPT_EDGE_BIT     = 6;
    // Reset values
    localparam logic [7:0]  OPTION_RESET   = 8'hff;
    localparam logic [7:0]  DIR_RESET      = 8'hff;
    localparam logic [6:0]  INTCTL_RESET   = 7'h00;
    // Pin roles
    localparam int          EXT_PIN        = 0;
    localparam int          LVP_PIN        = 4;
    localparam int          UPPER_LO       = 4;
    localparam logic [1:0]  ARM_DONE       = 2'h3;
    // AXI responses
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef struct packed {
        logic global_irq_enable;
        logic peripheral_irq_enable;
        logic t0ie;
        logic ext_pin_irq_enable;
        logic port_change_irq_enable;
        logic timer0_overflow_flag;
        logic ext_pin_irq_flag;
        logic port_change_flag;
    } icpb_intctl_type;

    typedef enum logic [2:0] {
        SEL_NONE   = 3'b000,
        SEL_PORT   = 3'b001,
        SEL_INTCTL = 3'b010,
        SEL_OPTION = 3'b011,
        SEL_DIR    = 3'b100
    } icpb_sel_type;
endpackage

/* icpb_pin_model.sv */
// Purpose: Far-side model of the port B pins
// Assumes: Bench sets the external levels and drive enables
// Notes:   A released pin without pull-up wanders every cycle
`timescale 1ns/100ps
`default_nettype none
module icpb_pin_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] out_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] pullup_i,
    input  wire logic [7:0] ext_i,
    input  wire logic [7:0] ext_en_i,
    output var  logic [7:0] pin_o
);
    logic [7:0] wander = 8'h00;
    always @(posedge clk_i) begin
        wander <= ~wander;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_o[i] = oe_i[i] ? out_i[i] : ext_en_i[i] ? ext_i[i] : pullup_i[i] ? 1'b1 : wander[i];
        end
    end
endmodule
`default_nettype wire

/* core_irq_control_port_b_sources_tb.sv */
// Purpose: Self-checking bench of the interrupt control and port B block
// Assumes: AXI4-Lite master tasks, pins from the far-side model
// Notes:   One task per scenario
`timescale 1ns/100ps
`default_nettype none
module core_irq_control_port_b_sources_tb
    import icpb_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        tmr = 0, periph = 0, lvp = 0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp;
    logic [7:0]  pin, pout, poe, ppu, opt;
    logic [7:0]  ext = 8'h00, ext_en = 8'hff;
    int          fail_count = 0, num_checks = 0;

    always #12.5 clk = ~clk;

    icpb_top uut (.CORE_CLK_I(clk), .RESETN_I(rst_n), .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid),
        .AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata), .AXI_WSTRB_I(4'hf), .AXI_WVALID_I(wvalid),
        .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready),
        .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready), .AXI_RDATA_O(rdata),
        .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready), .PORT_B_PIN_DATA_PIN_I(pin),
        .PORT_B_PIN_DATA_OUT_O(pout), .PORT_B_PIN_DATA_OE_O(poe), .PORT_B_PIN_DATA_PULLUP_O(ppu), .TIMER0_COUNT_OVF_I(tmr),
        .PERIPH_REQ_I(periph), .LVP_EN_I(lvp), .OPTION_O(opt), .IRQ_O(irq));

    icpb_pin_model far (.clk_i(clk), .out_i(pout), .oe_i(poe), .pullup_i(ppu), .ext_i(ext),
        .ext_en_i(ext_en), .pin_o(pin));

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [9:0] ix, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        int n;
        n = 0;
        awaddr <= {ix, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 40);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [9:0] ix, input logic [7:0] e, input logic [7:0] m = 8'hff,
                      input logic [1:0] er = RESP_OKAY);
        int n;
        n = 0;
        araddr <= {ix, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 40);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        chk("rdata", {24'h0, e & m}, rdata & {24'hffffff, m});
        rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic t_reset;
        rd(IDX_OPTION_B1, OPTION_RESET);
        rd(IDX_DIR_B3, DIR_RESET);
        rd(IDX_INTCTL_B0, 8'h00, 8'hfe);
        chk("oe", 8'h00, poe);
        chk("option_o", OPTION_RESET, opt);
        rd(10'h001, 8'h00, 8'hff, RESP_SLVERR);
        wr(10'h3ff, 8'h55, RESP_SLVERR);
    endtask

    task automatic t_alias;
        logic [9:0] ix [4];
        ix = '{IDX_INTCTL_B0, IDX_INTCTL_B1, IDX_INTCTL_B2, IDX_INTCTL_B3};
        wr(IDX_INTCTL_B3, 8'h28);
        foreach (ix[i]) rd(ix[i], 8'h28);
        wr(IDX_INTCTL_B2, 8'h00);
        foreach (ix[i]) rd(ix[i], 8'h00);
    endtask

    task automatic t_timer;
        tmr <= 1'b1;
        cyc(1);
        tmr <= 1'b0;
        cyc(2);
        rd(IDX_INTCTL_B0, 8'h04);
        chk("irq", 1'b0, irq);
        wr(IDX_INTCTL_B1, 8'ha4);
        cyc(2);
        chk("irq", 1'b1, irq);
        wr(IDX_INTCTL_B0, 8'h24);
        cyc(2);
        chk("irq", 1'b0, irq);
        rd(IDX_INTCTL_B0, 8'h24);
        wr(IDX_INTCTL_B0, 8'h00);
        rd(IDX_INTCTL_B0, 8'h00);
    endtask

    task automatic t_periph;
        periph <= 1'b1;
        wr(IDX_INTCTL_B0, 8'h80);
        cyc(2);
        chk("irq", 1'b0, irq);
        wr(IDX_INTCTL_B0, 8'hc0);
        cyc(2);
        chk("irq", 1'b1, irq);
        wr(IDX_INTCTL_B0, 8'h40);
        cyc(2);
        chk("irq", 1'b0, irq);
        periph <= 1'b0;
        wr(IDX_INTCTL_B0, 8'h00);
    endtask

    task automatic t_pin;
        ext <= 8'h01;
        cyc(6);
        rd(IDX_INTCTL_B0, 8'h02);
        wr(IDX_INTCTL_B0, 8'h82);
        cyc(2);
        chk("irq", 1'b0, irq);
        wr(IDX_INTCTL_B0, 8'h92);
        cyc(2);
        chk("irq", 1'b1, irq);
        wr(IDX_INTCTL_B0, 8'h00);
        ext <= 8'h00;
        cyc(6);
        rd(IDX_INTCTL_B0, 8'h00);
    endtask

    task automatic t_change;
        ext <= 8'h20;
        cyc(6);
        rd(IDX_INTCTL_B0, 8'h01);
        wr(IDX_INTCTL_B0, 8'h81);
        cyc(2);
        chk("irq", 1'b0, irq);
        wr(IDX_INTCTL_B0, 8'h89);
        cyc(2);
        chk("irq", 1'b1, irq);
        rd(IDX_INTCTL_B0, 8'h89);
        wr(IDX_INTCTL_B0, 8'h00);
        lvp <= 1'b1;
        ext <= 8'h30;
        cyc(6);
        rd(IDX_INTCTL_B0, 8'h00);
    endtask

    task automatic t_pullup;
        wr(IDX_OPTION_B3, 8'h3f);
        ext_en <= 8'hfd;
        ext <= 8'h31;
        cyc(6);
        chk("option_o", 8'h3f, opt);
        chk("pullup", 8'hef, ppu);
        rd(IDX_PORT_B2, 8'h33);
        rd(IDX_INTCTL_B0, 8'h00);
        ext <= 8'h30;
        cyc(6);
        rd(IDX_INTCTL_B0, 8'h02);
        wr(IDX_INTCTL_B0, 8'h00);
        lvp <= 1'b0;
        cyc(3);
        chk("pullup", 8'hff, ppu);
    endtask

    task automatic t_port;
        wr(IDX_DIR_B1, 8'h0f);
        wr(IDX_PORT_B0, 8'ha5);
        cyc(2);
        chk("oe", 8'hf0, poe);
        chk("out", 8'ha5, pout);
        chk("pullup", 8'h0f, ppu);
        rd(IDX_PORT_B0, 8'ha2);
    endtask

    task automatic t_reset2;
        wr(IDX_INTCTL_B0, 8'he8);
        rst_n <= 1'b0;
        cyc(6);
        rst_n <= 1'b1;
        cyc(3);
        rd(IDX_DIR_B1, DIR_RESET);
        rd(IDX_OPTION_B1, OPTION_RESET);
        chk("out", 8'ha5, pout);
        rd(IDX_INTCTL_B1, 8'h00, 8'hfe);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        cyc(3);
        t_reset();
        t_alias();
        t_timer();
        t_periph();
        t_pin();
        t_change();
        t_pullup();
        t_port();
        t_reset2();
        stop_test();
    end

    initial begin
        repeat (4000) @(posedge clk);
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
